//--- inc/dll_switch_pkg.sv
// constants, register map and sequencer states of the dll switch controller
package dll_switch_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // memory clock and delay conversion
  localparam int unsigned CK_AVG_PERIOD_NS = 125;

  // a nanosecond delay rounds up to whole memory clock cycles, never zero
  function automatic logic [15:0] ns_to_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns + CK_AVG_PERIOD_NS - 1) / CK_AVG_PERIOD_NS;
    if (c == 0) begin
      c = 1;
    end
    return 16'(c);
  endfunction

  localparam int unsigned ENTRY_HOLD_NS  = 10;
  localparam int unsigned EXIT_STABLE_NS = 10;
  localparam int unsigned EXIT_DELAY_NS  = 270;
  localparam int unsigned MODE_UPDATE_NS = 15;

  localparam logic [15:0] RST_CKSRE  = ns_to_cycles(ENTRY_HOLD_NS);
  localparam logic [15:0] RST_CKSRX  = ns_to_cycles(EXIT_STABLE_NS);
  localparam logic [15:0] RST_XS     = ns_to_cycles(EXIT_DELAY_NS);
  localparam logic [15:0] RST_MOD    = ns_to_cycles(MODE_UPDATE_NS);
  localparam logic [15:0] RST_MRD    = 16'h0004;
  localparam logic [15:0] RST_DLLK   = 16'h0200;
  localparam logic [15:0] RST_ZQOPER = 16'h0100;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses) and fields
  localparam logic [5:0] OFS_CTRL   = 6'h00;
  localparam logic [5:0] OFS_STATUS = 6'h04;
  localparam logic [5:0] OFS_MODE0  = 6'h08;
  localparam logic [5:0] OFS_MODE1  = 6'h0c;
  localparam logic [5:0] OFS_MODE2  = 6'h10;
  localparam logic [5:0] OFS_CKSRE  = 6'h14;
  localparam logic [5:0] OFS_CKSRX  = 6'h18;
  localparam logic [5:0] OFS_XS     = 6'h1c;
  localparam logic [5:0] OFS_MRD    = 6'h20;
  localparam logic [5:0] OFS_MOD    = 6'h24;
  localparam logic [5:0] OFS_DLLK   = 6'h28;
  localparam logic [5:0] OFS_ZQOPER = 6'h2c;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_DIR_BIT   = 1;
  localparam int CTRL_ZQ_BIT    = 2;
  localparam int CTRL_ODT_BIT   = 3;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_DONE_BIT  = 1;
  localparam int STAT_ODT_BIT   = 2;
  localparam int STAT_ZQ_BIT    = 3;
  localparam int STAT_STATE_LSB = 8;

  localparam logic [15:0] RST_MODE0 = 16'h0000;
  localparam logic [15:0] RST_MODE1 = 16'h0000;
  localparam logic [15:0] RST_MODE2 = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // mode word bits, mode register selects, command codes {cs,ras,cas,we}
  localparam int DLL_DISABLE_BIT = 0;
  localparam int DLL_RESET_BIT   = 8;
  localparam int CAL_LONG_BIT    = 10;

  localparam logic [2:0] BA_PRIMARY   = 3'h0;
  localparam logic [2:0] BA_SECONDARY = 3'h1;
  localparam logic [2:0] BA_THIRD     = 3'h2;

  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_CAL = 4'h6;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer states
  typedef enum logic [20:0] {
    S_IDLE       = 21'h00_0001,
    S_OFF_MRS    = 21'h00_0002,
    S_WAIT_OFF   = 21'h00_0004,
    S_SRE        = 21'h00_0008,
    S_WAIT_CKSRE = 21'h00_0010,
    S_CLK_CHG    = 21'h00_0020,
    S_WAIT_CKSRX = 21'h00_0040,
    S_SRX        = 21'h00_0080,
    S_WAIT_XS    = 21'h00_0100,
    S_EN_MRS     = 21'h00_0200,
    S_WAIT_EN    = 21'h00_0400,
    S_RST_MRS    = 21'h00_0800,
    S_WAIT_RST   = 21'h00_1000,
    S_MRS_A      = 21'h00_2000,
    S_WAIT_A     = 21'h00_4000,
    S_MRS_B      = 21'h00_8000,
    S_WAIT_B     = 21'h01_0000,
    S_MRS_C      = 21'h02_0000,
    S_WAIT_MOD   = 21'h04_0000,
    S_ZQ         = 21'h08_0000,
    S_WAIT_LOCK  = 21'h10_0000
  } seq_state_e;

endpackage

//--- hw/pin_sync.sv
// two-stage synchroniser with a rising edge pulse behind it
`timescale 1ns/10ps
module pin_sync
  import dll_switch_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_s;

  sync_s q;
  sync_s d;

  // s1 feeds s2 only; the edge is found between s2 and s3
  always_comb begin
    d    = q;
    d.s1 = pin_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level = q.s2;
  assign rise  = q.s2 & ~q.s3;

endmodule

//--- hw/edge_counter.sv
// down counter of memory clock edges, loaded with a wait length
`timescale 1ns/10ps
module edge_counter
  import dll_switch_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        load,
  input  wire logic [15:0] value,
  input  wire logic        tick,
  output logic             zero
);

  typedef struct packed {
    logic [15:0] cnt;
  } cnt_s;

  cnt_s q;
  cnt_s d;

  // a zero length is taken as one edge so no wait is ever skipped
  always_comb begin
    d = q;
    if (load) begin
      d.cnt = (value == 16'h0000) ? 16'h0001 : value;
    end else if (tick && q.cnt != 16'h0000) begin
      d.cnt = q.cnt - 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign zero = (q.cnt == 16'h0000);

endmodule

//--- hw/dll_switch_ctrl.sv
// controller that walks a memory device through dll on/off switching
`timescale 1ns/10ps
module dll_switch_ctrl
  import dll_switch_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        dram_ck,
  output logic             dram_cke,
  output logic             dram_cs_n,
  output logic             dram_ras_n,
  output logic             dram_cas_n,
  output logic             dram_we_n,
  output logic      [2:0]  dram_ba,
  output logic      [15:0] dram_addr,
  output logic             dram_odt,
  output logic             clk_change_req,
  input  wire logic        clk_change_done
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    seq_state_e  st;
    logic        cke;
    logic [3:0]  cmd;
    logic [2:0]  ba;
    logic [15:0] addr;
    logic        termination_control_input;
    logic        clk_req;
    logic        off_to_on;
    logic        zq_en;
    logic        odt_on;
    logic        zq_used;
    logic        done;
    logic [15:0] mode0;
    logic [15:0] mode1;
    logic [15:0] mode2;
    logic [15:0] t_cksre;
    logic [15:0] t_cksrx;
    logic [15:0] t_xs;
    logic [15:0] t_mrd;
    logic [15:0] t_mod;
    logic [15:0] t_dllk;
    logic [15:0] t_zqoper;
    logic [31:0] rdata;
  } ctrl_s;

  localparam ctrl_s Q_RST = '{
    st: S_IDLE, cke: 1'b1, cmd: CMD_NOP, ba: 3'h0, addr: 16'h0000,
    termination_control_input: 1'b0, clk_req: 1'b0, off_to_on: 1'b0, zq_en: 1'b0,
    odt_on: 1'b0, zq_used: 1'b0, done: 1'b0,
    mode0: RST_MODE0, mode1: RST_MODE1, mode2: RST_MODE2,
    t_cksre: RST_CKSRE, t_cksrx: RST_CKSRX, t_xs: RST_XS,
    t_mrd: RST_MRD, t_mod: RST_MOD, t_dllk: RST_DLLK,
    t_zqoper: RST_ZQOPER, rdata: 32'h0000_0000
  };

  ctrl_s       q;
  ctrl_s       d;
  logic        ck_rise;
  logic        done_lvl;
  logic        step_load;
  logic [15:0] step_val;
  logic        step_zero;
  logic        lock_load;
  logic        lock_zero;
  logic        start;

  // command, bank select and address word for one mode write
  function automatic logic [22:0] mode_write(input logic [2:0]  ba,
                                             input logic [15:0] a);
    return {CMD_MRS, ba, a};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // memory clock edges and clock generator answer, both from other domains

  pin_sync u_ck_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin_in  (dram_ck),
    .level   (),
    .rise    (ck_rise)
  );

  pin_sync u_done_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin_in  (clk_change_done),
    .level   (done_lvl),
    .rise    ()
  );

  // step counter times each wait; lock counter runs beside the later steps
  edge_counter u_step (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .load    (step_load),
    .value   (step_val),
    .tick    (ck_rise),
    .zero    (step_zero)
  );

  edge_counter u_lock (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .load    (lock_load),
    .value   (q.t_dllk),
    .tick    (ck_rise),
    .zero    (lock_zero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register port and sequencer

  assign start = reg_wr && reg_addr == OFS_CTRL && reg_wdata[CTRL_START_BIT];

  always_comb begin
    d         = q;
    step_load = 1'b0;
    step_val  = q.t_mrd;
    lock_load = 1'b0;
    d.rdata   = 32'h0000_0000;
    // timing and mode words are only taken while the sequencer is idle
    if (reg_wr && q.st == S_IDLE) begin
      case (reg_addr)
        OFS_MODE0:  d.mode0    = reg_wdata[15:0];
        OFS_MODE1:  d.mode1    = reg_wdata[15:0];
        OFS_MODE2:  d.mode2    = reg_wdata[15:0];
        OFS_CKSRE:  d.t_cksre  = reg_wdata[15:0];
        OFS_CKSRX:  d.t_cksrx  = reg_wdata[15:0];
        OFS_XS:     d.t_xs     = reg_wdata[15:0];
        OFS_MRD:    d.t_mrd    = reg_wdata[15:0];
        OFS_MOD:    d.t_mod    = reg_wdata[15:0];
        OFS_DLLK:   d.t_dllk   = reg_wdata[15:0];
        OFS_ZQOPER: d.t_zqoper = reg_wdata[15:0];
        default: ;
      endcase
    end
    // read data stand for the one cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL: begin
          d.rdata[CTRL_DIR_BIT] = q.off_to_on;
          d.rdata[CTRL_ZQ_BIT]  = q.zq_en;
          d.rdata[CTRL_ODT_BIT] = q.odt_on;
        end
        OFS_STATUS: begin
          d.rdata[STAT_BUSY_BIT] = (q.st != S_IDLE);
          d.rdata[STAT_DONE_BIT] = q.done;
          d.rdata[STAT_ODT_BIT]  = q.odt_on;
          d.rdata[STAT_ZQ_BIT]   = q.zq_used;
          d.rdata[STAT_STATE_LSB +: 21] = q.st;
        end
        OFS_MODE0:  d.rdata = {16'h0000, q.mode0};
        OFS_MODE1:  d.rdata = {16'h0000, q.mode1};
        OFS_MODE2:  d.rdata = {16'h0000, q.mode2};
        OFS_CKSRE:  d.rdata = {16'h0000, q.t_cksre};
        OFS_CKSRX:  d.rdata = {16'h0000, q.t_cksrx};
        OFS_XS:     d.rdata = {16'h0000, q.t_xs};
        OFS_MRD:    d.rdata = {16'h0000, q.t_mrd};
        OFS_MOD:    d.rdata = {16'h0000, q.t_mod};
        OFS_DLLK:   d.rdata = {16'h0000, q.t_dllk};
        OFS_ZQOPER: d.rdata = {16'h0000, q.t_zqoper};
        default:    d.rdata = 32'h0000_0000;
      endcase
    end
    // a command lasts one memory clock, then the pins fall back to nop
    if (ck_rise) begin
      d.cmd = CMD_NOP;
    end
    // termination input is never raised here, which covers both cases
    d.termination_control_input = 1'b0;
    case (q.st)
      S_IDLE: begin
        // software starts only once the device is idle and precharged
        if (start) begin
          d.off_to_on = reg_wdata[CTRL_DIR_BIT];
          d.zq_en     = reg_wdata[CTRL_ZQ_BIT];
          d.odt_on    = reg_wdata[CTRL_ODT_BIT];
          d.done      = 1'b0;
          d.zq_used   = 1'b0;
          d.st        = reg_wdata[CTRL_DIR_BIT] ? S_SRE : S_OFF_MRS;
        end
      end
      S_OFF_MRS: begin
        // issue just after a sampled edge, so the nop of that edge
        // cannot cut the command before the device has registered it
        if (ck_rise) begin
          {d.cmd, d.ba, d.addr} = mode_write(BA_SECONDARY,
            q.mode1 | (16'h0001 << DLL_DISABLE_BIT));
          step_load = 1'b1;
          step_val  = q.t_mod;
          d.st      = S_WAIT_OFF;
        end
      end
      S_WAIT_OFF: begin
        if (step_zero) begin
          d.st = S_SRE;
        end
      end
      S_SRE: begin
        // reached straight from a start too, so it waits for an edge
        if (ck_rise) begin
          d.cmd     = CMD_REF;
          d.cke     = 1'b0;
          step_load = 1'b1;
          step_val  = q.t_cksre;
          d.st      = S_WAIT_CKSRE;
        end
      end
      S_WAIT_CKSRE: begin
        // the clock is only touched after the hold, and after the
        // generator has dropped its previous answer; the count includes
        // the entry edge, so one more edge is let through before asking
        if (step_zero && ck_rise && !done_lvl) begin
          d.clk_req = 1'b1;
          d.st      = S_CLK_CHG;
        end
      end
      S_CLK_CHG: begin
        // edges counted for the stable time are those of the new clock
        if (done_lvl) begin
          d.clk_req = 1'b0;
          step_load = 1'b1;
          step_val  = q.t_cksrx;
          d.st      = S_WAIT_CKSRX;
        end
      end
      S_WAIT_CKSRX: begin
        if (step_zero) begin
          d.st = S_SRX;
        end
      end
      S_SRX: begin
        d.cmd     = CMD_NOP;
        d.cke     = 1'b1;
        step_load = 1'b1;
        step_val  = q.t_xs;
        d.st      = S_WAIT_XS;
      end
      S_WAIT_XS: begin
        if (step_zero) begin
          d.st = q.off_to_on ? S_EN_MRS : S_MRS_A;
        end
      end
      S_EN_MRS: begin
        {d.cmd, d.ba, d.addr} = mode_write(BA_SECONDARY,
          q.mode1 & ~(16'h0001 << DLL_DISABLE_BIT));
        step_load = 1'b1;
        d.st      = S_WAIT_EN;
      end
      S_WAIT_EN: begin
        if (step_zero) begin
          d.st = S_RST_MRS;
        end
      end
      S_RST_MRS: begin
        {d.cmd, d.ba, d.addr} = mode_write(BA_PRIMARY,
          q.mode0 | (16'h0001 << DLL_RESET_BIT));
        step_load = 1'b1;
        lock_load = 1'b1;
        d.st      = S_WAIT_RST;
      end
      S_WAIT_RST: begin
        if (step_zero) begin
          d.st = S_MRS_A;
        end
      end
      S_MRS_A: begin
        // new latencies for the new clock; the reset bit is not repeated
        {d.cmd, d.ba, d.addr} = mode_write(BA_PRIMARY,
          q.mode0 & ~(16'h0001 << DLL_RESET_BIT));
        step_load = 1'b1;
        d.st      = S_WAIT_A;
      end
      S_WAIT_A: begin
        if (step_zero) begin
          d.st = S_MRS_B;
        end
      end
      S_MRS_B: begin
        {d.cmd, d.ba, d.addr} = mode_write(BA_THIRD, q.mode2);
        step_load = 1'b1;
        d.st      = S_WAIT_B;
      end
      S_WAIT_B: begin
        if (step_zero) begin
          d.st = S_MRS_C;
        end
      end
      S_MRS_C: begin
        // last mode write keeps the dll setting of the chosen direction
        if (q.off_to_on) begin
          {d.cmd, d.ba, d.addr} = mode_write(BA_SECONDARY,
            q.mode1 & ~(16'h0001 << DLL_DISABLE_BIT));
        end else begin
          {d.cmd, d.ba, d.addr} = mode_write(BA_SECONDARY,
            q.mode1 | (16'h0001 << DLL_DISABLE_BIT));
        end
        step_load = 1'b1;
        step_val  = q.t_mod;
        d.st      = S_WAIT_MOD;
      end
      S_WAIT_MOD: begin
        if (step_zero) begin
          d.st = (q.off_to_on && q.zq_en) ? S_ZQ : S_WAIT_LOCK;
        end
      end
      S_ZQ: begin
        d.cmd                  = CMD_CAL;
        d.addr                 = 16'h0000;
        d.addr[CAL_LONG_BIT]   = 1'b1;
        d.zq_used              = 1'b1;
        step_load              = 1'b1;
        step_val               = q.t_zqoper;
        d.st                   = S_WAIT_LOCK;
      end
      S_WAIT_LOCK: begin
        // done only when any calibration time and, when switching on, the lock time have run out
        if (step_zero && (lock_zero || !q.off_to_on)) begin
          d.done = 1'b1;
          d.st   = S_IDLE;
        end
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= Q_RST;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata      = q.rdata;
  assign dram_cke       = q.cke;
  assign dram_cs_n      = q.cmd[3];
  assign dram_ras_n     = q.cmd[2];
  assign dram_cas_n     = q.cmd[1];
  assign dram_we_n      = q.cmd[0];
  assign dram_ba        = q.ba;
  assign dram_addr      = q.addr;
  assign dram_odt       = q.termination_control_input;
  assign clk_change_req = q.clk_req;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_cke_held: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !q.cke |-> (q.st == S_WAIT_CKSRE || q.st == S_CLK_CHG
      || q.st == S_WAIT_CKSRX || q.st == S_SRX))
    else $error("clock enable dropped outside self refresh");

  chk_odt_low: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (q.st != S_IDLE) |-> !q.termination_control_input)
    else $error("termination input raised during switch");

  chk_sre_cke: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(q.clk_req) |-> !q.cke && $past(step_zero))
    else $error("clock change asked without self refresh hold");

  chk_dll_enable: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (q.st == S_EN_MRS) |=> q.cmd == CMD_MRS && q.ba == BA_SECONDARY
      && !q.addr[DLL_DISABLE_BIT])
    else $error("dll enable write malformed");

  chk_dll_reset: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (q.st == S_RST_MRS) |=> q.cmd == CMD_MRS && q.ba == BA_PRIMARY
      && q.addr[DLL_RESET_BIT])
    else $error("dll reset write malformed");

  chk_dll_disable: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (q.st == S_OFF_MRS && ck_rise) |=> q.cmd == CMD_MRS
      && q.ba == BA_SECONDARY && q.addr[DLL_DISABLE_BIT])
    else $error("dll disable write malformed");

  chk_clk_req_only: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    q.clk_req |-> q.st == S_CLK_CHG)
    else $error("clock change request outside its step");

  chk_nop_wait: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (ck_rise && (q.st == S_WAIT_EN || q.st == S_WAIT_RST
      || q.st == S_WAIT_A || q.st == S_WAIT_XS)) |=> q.cmd == CMD_NOP)
    else $error("command other than nop during a wait");

  chk_lock_done: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    ($fell(q.st == S_WAIT_LOCK) && q.off_to_on) |-> q.done
      && $past(lock_zero) && $past(step_zero))
    else $error("sequence ended before lock time");

endmodule

//--- verif/dram_model.sv
// behavioural memory device that decodes and polices the command pins
`timescale 1ns/10ps
module dram_model
  import dll_switch_pkg::*;
#(
  parameter int MRD = 4,
  parameter int XS  = 3
) (
  input  wire logic        ck,
  input  wire logic        cke,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [2:0]  ba,
  input  wire logic [15:0] addr,
  input  wire logic        termination_control_input,
  output logic      [15:0] m0,
  output logic      [15:0] m1,
  output logic      [15:0] m2,
  output logic             dll_on,
  output int               rsts,
  output int               zqs,
  output int               srxs,
  output int               errs,
  output int               strobe_lat
);
  // dll-off only has to support read and write latency six
  localparam int OFF_LATENCY = 6;

  logic [3:0] cmd;
  logic       sr;
  int         gap;
  int         since_x;

  assign cmd = {cs_n, ras_n, cas_n, we_n};

  // read strobe start, no additive latency; a cycle earlier with dll off
  assign strobe_lat = OFF_LATENCY - (dll_on ? 0 : 1);

  // power-up: initialised, dll running, far from any previous command
  initial begin
    {m0, m1, m2} = '0;
    {rsts, zqs, srxs, errs} = '0;
    dll_on = 1'b1;
    sr = 1'b0;
    gap = 99;
    since_x = 99;
  end

  // commands count in real clock edges, so a stopped clock adds no time
  always @(posedge ck) begin
    gap++;
    since_x++;
    if (termination_control_input) errs++;
    if (sr && cke) begin
      sr = 1'b0;
      srxs++;
      since_x = 0;
    end else if (!cs_n && cmd != CMD_NOP) begin
      if (since_x < XS) errs++;
      if (cmd == CMD_REF && !cke) sr = 1'b1;
      else if (cmd == CMD_CAL && addr[CAL_LONG_BIT]) zqs++;
      else if (cmd == CMD_MRS) begin
        if (gap < MRD) errs++;
        gap = 0;
        if (ba == BA_PRIMARY) begin
          m0 = addr;
          if (addr[DLL_RESET_BIT]) rsts++;
        end else if (ba == BA_SECONDARY) begin
          m1 = addr;
          dll_on = !addr[DLL_DISABLE_BIT];
        end else m2 = addr;
      end
    end
    if (!cke && !sr) errs++;
  end
endmodule

//--- verif/test_dll_switch_ctrl.sv
// self-checking bench for the dll switch controller
`timescale 1ns/10ps
module test_dll_switch_ctrl
  import dll_switch_pkg::*;
;
  typedef struct {
    logic [5:0]  a;
    logic [31:0] wd;
    logic [31:0] ex;
  } row_s;

  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        dram_ck = 1'b0;
  logic        clk_change_done = 1'b0;
  logic        ck_run = 1'b1;
  logic        cke, cs_n, ras_n, cas_n, we_n, termination_control_input, clk_change_req;
  logic [2:0]  ba;
  logic [15:0] addr, m0, m1, m2;
  logic        dll_on;
  logic [31:0] s;
  int          rsts, zqs, srxs, errs, strobe_lat;
  int          failures = 0;
  int          checks = 0;

  // write, then read back; the unmapped row must stay silent and the
  // control fields only latch together with a start
  row_s rows [9] = '{
    '{OFS_MODE0,  32'h0000_1320, 32'h0000_1320},
    '{OFS_MODE1,  32'h0000_0045, 32'h0000_0045},
    '{OFS_MODE2,  32'h0000_0018, 32'h0000_0018},
    '{OFS_DLLK,   32'hffff_0008, 32'h0000_0008},
    '{OFS_ZQOPER, 32'h0000_0004, 32'h0000_0004},
    '{OFS_MRD,    32'h0000_0005, 32'h0000_0005},
    '{OFS_XS,     32'h0000_0004, 32'h0000_0004},
    '{6'h30,      32'hffff_ffff, 32'h0000_0000},
    '{OFS_CTRL,   32'h0000_000e, 32'h0000_0000}
  };
  row_s rst_rows [9] = '{
    '{OFS_CKSRE,  '0, 32'h0000_0001}, '{OFS_CKSRX, '0, 32'h0000_0001},
    '{OFS_XS,     '0, 32'h0000_0003}, '{OFS_MOD,   '0, 32'h0000_0001},
    '{OFS_MRD,    '0, 32'h0000_0004}, '{OFS_DLLK,  '0, 32'h0000_0200},
    '{OFS_ZQOPER, '0, 32'h0000_0100}, '{OFS_MODE0, '0, 32'h0000_0000},
    '{OFS_STATUS, '0, 32'h0000_0100}
  };

  dll_switch_ctrl dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .dram_ck(dram_ck), .dram_cke(cke),
    .dram_cs_n(cs_n), .dram_ras_n(ras_n), .dram_cas_n(cas_n),
    .dram_we_n(we_n), .dram_ba(ba), .dram_addr(addr), .dram_odt(termination_control_input),
    .clk_change_req(clk_change_req), .clk_change_done(clk_change_done)
  );

  dram_model mem (
    .ck(dram_ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr), .termination_control_input(termination_control_input), .m0(m0), .m1(m1),
    .m2(m2), .dll_on(dll_on), .rsts(rsts), .zqs(zqs), .srxs(srxs),
    .errs(errs), .strobe_lat(strobe_lat)
  );

  ////////////////////////////////////////////////////////////////////////////
  // system clock, and a memory clock that stops during the change
  always #5 ref_clk = ~ref_clk;
  always #62.5 if (ck_run) dram_ck = ~dram_ck;

  // clock generator: stop, restart, then report done until released
  always begin
    wait (clk_change_req === 1'b1);
    ck_run = 1'b0;
    repeat (40) @(posedge ref_clk);
    ck_run = 1'b1;
    repeat (10) @(posedge ref_clk);
    clk_change_done <= 1'b1;
    wait (clk_change_req === 1'b0);
    @(posedge ref_clk) clk_change_done <= 1'b0;
  end

  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk) reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // polls status under a bound so a stuck sequencer cannot hang the run
  task automatic wait_done();
    logic [31:0] v;
    v = '0;
    for (int n = 0; n < 4000 && v[1] !== 1'b1; n++) rd(OFS_STATUS, v);
    if (v[1] !== 1'b1) begin
      failures++;
      $display("unexpected %0t: sequence never finished", $time);
      end_of_test();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].wd);
      rd(rows[i].a, s);
      chk(s, rows[i].ex, "readback");
    end
    $display("test register rows done");
    @(posedge ref_clk) rst_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (rst_rows[i]) begin
      rd(rst_rows[i].a, s);
      chk(s, rst_rows[i].ex, "reset value");
    end
    $display("test reset values done");
    foreach (rows[i]) wr(rows[i].a, rows[i].wd);
    wr(OFS_CTRL, 32'h0000_0007);
    wr(OFS_CTRL, 32'h0000_0007);
    wr(OFS_DLLK, 32'h0000_0010);
    rd(OFS_STATUS, s);
    chk({31'h0, s[0]}, 32'h0000_0001, "busy");
    wait_done();
    rd(OFS_STATUS, s);
    chk(s, 32'h0000_010a, "status after on");
    rd(OFS_DLLK, s);
    chk(s, 32'h0000_0008, "write while busy");
    rd(OFS_CTRL, s);
    chk(s, 32'h0000_0006, "ctrl fields");
    chk(32'(strobe_lat), 32'h0000_0006, "strobe on");
    chk(32'(m1), 32'h0000_0044, "enable word");
    chk({m2, m0}, 32'h0018_1220, "new mode words");
    chk({8'(rsts), 8'(zqs), 8'(srxs), 8'(errs)}, 32'h0101_0100,
        "on events");
    $display("test dll off to on done");
    wr(OFS_CTRL, 32'h0000_0001);
    wait_done();
    chk({m1, 15'h0, dll_on}, 32'h0045_0000, "dll off");
    chk(32'(strobe_lat), 32'h0000_0005, "strobe off");
    chk({8'(rsts), 8'(zqs), 8'(srxs), 8'(errs)}, 32'h0101_0200,
        "off events");
    $display("test dll on to off done");
    end_of_test();
  end
endmodule
